/* File: shared/adc_seq_pkg.sv */
// Package of register offsets, field positions and timing constants for the converter sequencer
package adc_seq_pkg;
   // ***************************************************************
   // Register map (byte addresses on APB)
   // ***************************************************************
   localparam logic [7:0] ctrl_addr      = 8'h00;
   localparam logic [7:0] result_1_addr  = 8'h04;
   localparam logic [7:0] result_2_addr  = 8'h08;
   localparam logic [7:0] result_3_addr  = 8'h0c;
   localparam logic [7:0] result_4_addr  = 8'h10;
   localparam logic [7:0] addr_word_mask = 8'hfc;
   // ***************************************************************
   // Control register fields
   // ***************************************************************
   localparam int done_bit      = 7;
   localparam int unimpl_bit    = 6;
   localparam int scan_bit      = 5;
   localparam int group_bit     = 4;
   localparam int sel_hi        = 3;
   localparam int sel_lo        = 0;
   localparam logic [7:0] ctrl_reset    = 8'h00;
   localparam logic [7:0] ctrl_wr_mask  = 8'h3f;
   // ***************************************************************
   // Channel codes
   // ***************************************************************
   localparam logic [3:0] code_high_ref = 4'hc;
   localparam logic [3:0] code_low_ref  = 4'hd;
   localparam logic [3:0] code_half_ref = 4'he;
   localparam logic [3:0] code_rsvd_top = 4'hf;
   localparam logic       ext_group_msb = 1'b0;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int conv_cycles   = 32;
   localparam int sample_cycles = 12;
   localparam int sar_bits      = 8;
   localparam int seq_len       = 4;
   localparam logic [5:0] cnt_zero = 6'h00;
   localparam logic [1:0] slot_zero = 2'h0;
   localparam logic [1:0] slot_last = 2'h3;
   localparam int stab_time_ms  = 10;
endpackage

/* File: logic/sar_step.sv */
// Successive-approximation step: one comparison on the trial bit per call
`timescale 1ns/1ps
`default_nettype none
module sar_step #(
   parameter int width = 8
) (
   input  wire logic [width-1:0] sar_in,     // Value so far
   input  wire logic [width-1:0] trial_bit,  // One-hot bit under test
   input  wire logic             cmp_high,   // Comparator: input at or above trial level
   output logic      [width-1:0] trial_out,  // Level offered to the comparator
   output logic      [width-1:0] sar_out     // Value after this comparison
);
   // ***************************************************************
   // Bit decision
   // ***************************************************************
   always_comb begin
      trial_out = sar_in | trial_bit;
      sar_out   = cmp_high ? trial_out : sar_in;
   end
endmodule
`default_nettype wire

/* File: logic/adc_sequence_control.sv */
// Sequencing and register logic of the multiplexed successive-approximation converter
// Overview of operation
// - Single mode converts the one selected channel four times in a row.
// - Codes 0000 to 0111 route analog inputs 0 to 7 in order.
// - 1100 high ref, 1101 low ref, 1110 half high ref; 10xx, 1111 reserved.
// - Group mode ignores two low select bits; upper two pick aligned group.
// - Group mode puts first channel in result 1, fourth in result 4.
// - Single one-shot fills results 1..4 then halts until next control write.
// - Single continuous keeps converting; fifth result overwrites result 1, cyclically.
// - Group one-shot converts four group channels once into results 1..4, stops.
// - Group continuous repeats group forever, fifth conversion replaces result 1.
// - Any control write starts a fresh sequence, abandoning any active one.
// - Done flag at bit 7 is read-only, set when all four results valid.
// - Each control write clears the done flag as the sequence starts.
// - Continuous scan sets done after first sequence; results keep updating.
// - Control bit 6 is unimplemented and reads zero.
// - Control bits 0 to 5 are writable and read back.
// - Stop or wait suspends conversion; resume resamples same channel, continues.
// - Result registers are read-only 8-bit; writes do nothing.
// - Sequence begins one clock cycle after the control write.
// - Eight comparisons from MSB; final value goes to its result register.
// - Sampling switch closed only during 12-cycle window starting each conversion.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_control #(
   parameter int data_width = 8
) (
   input  wire logic        clk,            // 100 MHz clock
   input  wire logic        rst,            // Asynchronous reset, active high
   input  wire logic        psel,           // APB select
   input  wire logic        penable,        // APB access phase
   input  wire logic        pwrite,         // APB write
   input  wire logic [7:0]  paddr,          // APB byte address
   input  wire logic [31:0] pwdata,         // APB write data
   input  wire logic [3:0]  pstrb,          // APB byte strobes
   output logic      [31:0] prdata,         // APB read data
   output logic             pready,         // APB ready
   output logic             pslverr,        // APB error on unmapped address
   input  wire logic        suspend,        // Stop or wait mode in force
   input  wire logic        cmp_high,       // Comparator result
   output logic      [3:0]  mux_select,     // Multiplexer channel code
   output logic             sample_switch,  // Input sampling switch closed
   output logic      [7:0]  dac_level,      // Trial level for the comparator
   output logic             converting      // Conversion in progress
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef enum logic [2:0] {
      st_idle    = 3'b001,
      st_start   = 3'b010,
      st_convert = 3'b100
   } seq_state_t;

   typedef struct packed {
      seq_state_t      state;
      logic [7:0]      ctrl;
      logic [5:0]      cyc;
      logic [1:0]      slot;
      logic [7:0]      sar;
      logic [7:0]      trial;
      logic [3:0][7:0] result;
      logic [31:0]     rdata;
      logic            pready;
      logic            slverr;
   } core_t;

   core_t s_r;
   core_t s_nxt;

   logic       wr_fire;
   logic       ctrl_hit;
   logic       mapped;
   logic [7:0] trial_level;
   logic [7:0] sar_next;
   logic [3:0] sel;
   logic [3:0] chan_code;

   sar_step #(
      .width(data_width)
   ) u_step (
      .sar_in    (s_r.sar),
      .trial_bit (s_r.trial),
      .cmp_high  (cmp_high),
      .trial_out (trial_level),
      .sar_out   (sar_next)
   );

   // ***************************************************************
   // Address decode
   // ***************************************************************
   always_comb begin
      wr_fire  = psel & penable & pwrite & s_r.pready;
      ctrl_hit = (paddr & adc_seq_pkg::addr_word_mask) == adc_seq_pkg::ctrl_addr;
      unique case (paddr & adc_seq_pkg::addr_word_mask)
         adc_seq_pkg::ctrl_addr,
         adc_seq_pkg::result_1_addr,
         adc_seq_pkg::result_2_addr,
         adc_seq_pkg::result_3_addr,
         adc_seq_pkg::result_4_addr: mapped = 1'b1;
         default:                    mapped = 1'b0;
      endcase
      sel = s_r.ctrl[adc_seq_pkg::sel_hi:adc_seq_pkg::sel_lo];
      if (s_r.ctrl[adc_seq_pkg::group_bit]) begin
         chan_code = {sel[3:2], s_r.slot};
      end else begin
         chan_code = sel;
      end
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_nxt        = s_r;
      s_nxt.pready = psel & ~(penable & s_r.pready);
      // Read data is captured at the setup edge so it stands while pready is high
      if (psel & ~penable & ~pwrite) begin
         s_nxt.rdata = 32'h0000_0000;
         unique case (paddr & adc_seq_pkg::addr_word_mask)
            adc_seq_pkg::ctrl_addr: begin
               s_nxt.rdata[7:0] = s_r.ctrl;
               s_nxt.rdata[adc_seq_pkg::unimpl_bit] = 1'b0;
            end
            adc_seq_pkg::result_1_addr: s_nxt.rdata[7:0] = s_r.result[0];
            adc_seq_pkg::result_2_addr: s_nxt.rdata[7:0] = s_r.result[1];
            adc_seq_pkg::result_3_addr: s_nxt.rdata[7:0] = s_r.result[2];
            adc_seq_pkg::result_4_addr: s_nxt.rdata[7:0] = s_r.result[3];
            default: s_nxt.rdata = 32'h0000_0000;
         endcase
      end
      if (psel & ~penable) begin
         s_nxt.slverr = ~mapped;
      end

      unique case (s_r.state)
         st_idle: begin
         end
         st_start: begin
            // One cycle after the write the first conversion begins
            s_nxt.state = st_convert;
            s_nxt.cyc   = adc_seq_pkg::cnt_zero;
            s_nxt.slot  = adc_seq_pkg::slot_zero;
            s_nxt.sar   = 8'h00;
            s_nxt.trial = 8'h80;
         end
         st_convert: begin
            if (suspend) begin
               // Restart the current channel from its sample window
               s_nxt.cyc   = adc_seq_pkg::cnt_zero;
               s_nxt.sar   = 8'h00;
               s_nxt.trial = 8'h80;
            end else begin
               s_nxt.cyc = s_r.cyc + 6'h01;
               if (s_r.cyc >= 6'(adc_seq_pkg::sample_cycles) &&
                   s_r.cyc < 6'(adc_seq_pkg::sample_cycles + adc_seq_pkg::sar_bits)) begin
                  s_nxt.sar   = sar_next;
                  s_nxt.trial = s_r.trial >> 1;
               end
               if (s_r.cyc == 6'(adc_seq_pkg::conv_cycles - 1)) begin
                  s_nxt.result[s_r.slot] = s_r.sar;
                  s_nxt.cyc   = adc_seq_pkg::cnt_zero;
                  s_nxt.sar   = 8'h00;
                  s_nxt.trial = 8'h80;
                  s_nxt.slot  = s_r.slot + 2'h1;
                  if (s_r.slot == adc_seq_pkg::slot_last) begin
                     s_nxt.ctrl[adc_seq_pkg::done_bit] = 1'b1;
                     if (!s_r.ctrl[adc_seq_pkg::scan_bit]) begin
                        s_nxt.state = st_idle;
                     end
                  end
               end
            end
         end
         default: s_nxt.state = st_idle;
      endcase

      // A control write wins over the state and control updates above, including a done set
      if (wr_fire && ctrl_hit && mapped) begin
         if (pstrb[0]) begin
            s_nxt.ctrl = pwdata[7:0] & adc_seq_pkg::ctrl_wr_mask;
         end else begin
            s_nxt.ctrl = s_r.ctrl & adc_seq_pkg::ctrl_wr_mask;
         end
         s_nxt.state = st_start;
      end
      // Result registers ignore writes
   end

   // ***************************************************************
   // Registers
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '{state: st_idle, ctrl: adc_seq_pkg::ctrl_reset, cyc: 6'h00,
                  slot: 2'h0, sar: 8'h00, trial: 8'h80, result: '0,
                  rdata: 32'h0000_0000, pready: 1'b0, slverr: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   always_comb begin
      prdata        = s_r.rdata;
      pready        = s_r.pready;
      pslverr       = s_r.pready & s_r.slverr;
      converting    = (s_r.state == st_convert);
      mux_select    = chan_code;
      sample_switch = converting && !suspend &&
                      (s_r.cyc < 6'(adc_seq_pkg::sample_cycles));
      dac_level     = trial_level;
   end
endmodule
`default_nettype wire

/* File: test/front_end_model.sv */
// Behavioural analog front end: input levels, sample hold and comparator
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
   input  wire logic       clk,            // Clock
   input  wire logic [3:0] mux_select,     // Channel code
   input  wire logic       sample_switch,  // Sampling switch closed
   input  wire logic [7:0] dac_level,      // Trial level
   output logic            cmp_high        // Input at or above trial level
);
   // ****
   // Each channel code carries its own fixed level
   // ****
   logic [7:0] held_r;
   always_ff @(posedge clk) begin
      if (sample_switch) begin
         held_r <= {mux_select, ~mux_select};
      end
   end
   assign cmp_high = held_r >= dac_level;
endmodule
`default_nettype wire

/* File: test/adc_seq_asserts.sv */
// Concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adc_seq_asserts (
   input wire logic        clk,            // Clock
   input wire logic        rst,            // Reset
   input wire logic        psel,           // APB select
   input wire logic        penable,        // APB enable
   input wire logic        pwrite,         // APB write
   input wire logic [7:0]  paddr,          // APB address
   input wire logic [31:0] prdata,         // APB read data
   input wire logic        pready,         // APB ready
   input wire logic        suspend,        // Stop or wait
   input wire logic        sample_switch,  // Sampling switch
   input wire logic [7:0]  dac_level,      // Trial level
   input wire logic        converting      // Busy
);
   // ****
   // Checks
   // ****
   logic done_c;
   logic wr_c;
   logic wr_d_r;
   // Marks the cycle after a control write, when the sequencer is in its start step
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_d_r <= 1'b0;
      end else begin
         wr_d_r <= wr_c;
      end
   end
   assign done_c = psel && penable && pready;
   assign wr_c = done_c && pwrite && paddr == 8'h00;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_start_delay: assert property (wr_c && !suspend ##1 !suspend |=> converting && sample_switch)
      else $error("sequence did not start one cycle after control write");
   a_sample_len: assert property (disable iff (rst || suspend || wr_c || wr_d_r)
      $rose(sample_switch) |-> sample_switch[*8] ##1 sample_switch[*4] ##1 !sample_switch)
      else $error("sample window is not twelve cycles");
   a_hold_len: assert property (disable iff (rst || suspend || wr_c || wr_d_r)
      $fell(sample_switch) |-> (!sample_switch)[*8] ##1 (!sample_switch)[*8] ##1 (!sample_switch)[*4])
      else $error("conversion length is not thirty-two cycles");
   a_trial_msb: assert property (sample_switch |-> dac_level == 8'h80)
      else $error("comparison does not start at the top bit");
   a_bit6_zero: assert property (done_c && !pwrite && paddr == 8'h00 |-> !prdata[6])
      else $error("control bit six read back as one");
   a_result_byte: assert property (done_c && !pwrite && paddr inside {[8'h04:8'h10]} |-> prdata[31:8] == 24'h0)
      else $error("result register wider than one byte");
   a_idle_open: assert property (!converting |-> !sample_switch)
      else $error("sampling while idle");
   a_suspend_open: assert property (suspend |-> !sample_switch)
      else $error("sampling while suspended");
endmodule
bind adc_sequence_control adc_seq_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .suspend(suspend), .sample_switch(sample_switch), .dac_level(dac_level),
   .converting(converting));
`default_nettype wire

/* File: test/adc_sequence_control_tb.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_control_tb;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, suspend = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'h1, mux_select;
   logic pready, pslverr, err, cmp_high, sample_switch, converting;
   logic [7:0] dac_level;
   int failures = 0, checks = 0, cycles = 0;
   always #5 clk = ~clk;
   adc_sequence_control dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .suspend(suspend), .cmp_high(cmp_high),
      .mux_select(mux_select), .sample_switch(sample_switch), .dac_level(dac_level),
      .converting(converting));
   front_end_model fe (.clk(clk), .mux_select(mux_select), .sample_switch(sample_switch),
      .dac_level(dac_level), .cmp_high(cmp_high));
   // ****
   // Shared tasks
   // ****
   task summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         summarize;
      end
   end
   function automatic logic [7:0] lvl(input logic [3:0] c);
      return {c, ~c};
   endfunction
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= {24'h0, d};
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wait_done;
      rd = 32'h0;
      for (int i = 0; i < 100 && rd[7] !== 1'b1; i++) apb(8'h00, 0, 8'h00);
      chk(rd[7], 1'b1);
   endtask
   task automatic results(input logic [3:0] c, input logic grp);
      for (int k = 0; k < 4; k++) begin
         apb(adc_seq_pkg::result_1_addr + 8'(4 * k), 0, 8'h00);
         chk(rd[7:0], lvl(c + (grp ? 4'(k) : 4'h0)));
      end
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_oneshot(input logic [7:0] cmd, input logic [3:0] c, input logic grp);
      apb(8'h00, 1, cmd);
      apb(8'h00, 0, 8'h00);
      chk(rd[7:0], cmd);
      wait_done;
      results(c, grp);
      repeat (40) @(posedge clk);
      chk(converting, 1'b0);
   endtask
   task automatic t_scan;
      apb(8'h00, 1, 8'h3c);
      wait_done;
      results(4'hc, 1);
      chk(converting, 1'b1);
      apb(adc_seq_pkg::result_1_addr, 1, 8'h55);
      apb(adc_seq_pkg::result_1_addr, 0, 8'h00);
      chk(rd[7:0], lvl(4'hc));
      apb(8'h20, 0, 8'h00);
      chk(err, 1'b1);
      apb(8'h00, 1, 8'h22);
      apb(8'h00, 0, 8'h00);
      chk(rd[7:0], 8'h22);
      wait_done;
      results(4'h2, 0);
      chk(converting, 1'b1);
   endtask
   task automatic t_suspend;
      apb(8'h00, 1, 8'h01);
      repeat (20) @(posedge clk);
      suspend <= 1;
      repeat (30) @(posedge clk);
      suspend <= 0;
      wait_done;
      results(4'h1, 0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      apb(8'h00, 0, 8'h00);
      chk(rd[7:0], adc_seq_pkg::ctrl_reset);
      t_oneshot(8'h03, 4'h3, 0);
      t_oneshot(8'h15, 4'h4, 1);
      t_scan;
      t_suspend;
      apb(8'h00, 1, 8'hff);
      apb(8'h00, 0, 8'h00);
      chk(rd[7:0], 8'h3f);
      summarize;
   end
endmodule
`default_nettype wire
